// file: logic/tcsf_params.svh
/*
  Constants for the timer control and status block: register address,
  bit positions, reset value, count limits and serial mode codes.
  Assumes it is included by bare name from the package and the design.
*/
`ifndef TCSF_PARAMS_SVH
`define TCSF_PARAMS_SVH
// Special function register address of the control/status byte.
`define TCSF_CTL_ADDR 8'hc9
// Reset value of the control/status byte.
`define TCSF_CTL_RESET 8'h00
// Bit positions inside the control/status byte.
`define TCSF_BIT_OVF 7
`define TCSF_BIT_EXF 6
`define TCSF_BIT_RXSEL 5
`define TCSF_BIT_TXSEL 4
`define TCSF_BIT_EXEN 3
`define TCSF_BIT_RUN 2
`define TCSF_BIT_CTSEL 1
`define TCSF_BIT_CRSEL 0
// Count limits of the 16-bit counter.
`define TCSF_CNT_MAX 16'hffff
`define TCSF_CNT_ZERO 16'h0000
// Variable-rate modes of the second serial port.
`define TCSF_UART_MODE1 2'h1
`define TCSF_UART_MODE3 2'h3
// Read value of an unmatched address.
`define TCSF_RD_IDLE 8'h00
`endif

// file: logic/tcsf_pkg.sv
/*
  Types shared by the timer control and status block.
  Assumes tcsf_params.svh is on the include path.
*/
`include "tcsf_params.svh"
package tcsf_pkg;
  // One register byte.
  typedef logic [7:0] tcsf_byte_t;
  // One counter word.
  typedef logic [15:0] tcsf_word_t;
  // Operating mode decoded from the control bits.
  typedef enum logic [1:0] {
    TCSF_OFF = 2'b00,
    TCSF_CAPTURE = 2'b01,
    TCSF_RELOAD = 2'b10,
    TCSF_BAUD = 2'b11
  } tcsf_mode_e;
endpackage : tcsf_pkg

// file: logic/tcsf_top.sv
/*
  Timer control/status register with its 16-bit counter, external
  trigger handling, interrupt request and serial shift clock selection.
  Assumes a single core clock, a synchronous reset, a count tick pulse
  from the prescaler on the same clock, and an asynchronous trigger pin.
*/
// Notes on behaviour
// - Overflow flag stays set until software clears.
// - No overflow flag while a baud select set.
// - Enabled trigger falling edge sets external flag.
// - External flag requests interrupt when enabled.
// - External flag holds; software writes zero.
// - Receive clock from this or other timer.
// - Transmit clock from this or other timer.
// - Selects pick the shift clocks only in serial modes 1, 3.
// - Trigger edges act only when enabled.
// - Wrap from maximum to zero sets overflow.
// - Baud select forces auto-reload counting.
// - Disabled trigger edges are ignored.
// - Counter advances only while run bit set.
`timescale 1ns/10ps
`include "tcsf_params.svh"
module tcsf_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire tcsf_pkg::tcsf_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire tcsf_pkg::tcsf_byte_t sfr_wdata,
  output tcsf_pkg::tcsf_byte_t sfr_rdata_r,
  input wire logic count_tick,
  input wire tcsf_pkg::tcsf_word_t reload_value,
  input wire logic ext_trigger_pin,
  input wire logic irq_enable,
  input wire logic other_timer_ovf,
  input wire logic [1:0] uart_mode,
  output tcsf_pkg::tcsf_word_t count_value_r,
  output logic capture_pulse_r,
  output logic counter_timer_select_r,
  output logic timer_irq_r,
  output logic rx_shift_tick_r,
  output logic tx_shift_tick_r
);
  import tcsf_pkg::*;

  // True when the serial port runs a variable-rate mode.
  function automatic logic is_var_mode(input logic [1:0] m);
    is_var_mode = (m == `TCSF_UART_MODE1) || (m == `TCSF_UART_MODE3);
  endfunction : is_var_mode

  // Control/status byte as software sees it.
  tcsf_byte_t ctl_r;
  tcsf_byte_t ctl_nxt;
  // Counter and its next value.
  tcsf_word_t cnt_nxt;
  // Two-stage synchroniser and a third stage for edge detection.
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_s3_r;

  // Named control bits.
  wire logic overflow_flag = ctl_r[`TCSF_BIT_OVF];
  wire logic external_event_flag = ctl_r[`TCSF_BIT_EXF];
  wire logic rx_baud_source_select = ctl_r[`TCSF_BIT_RXSEL];
  wire logic tx_baud_source_select = ctl_r[`TCSF_BIT_TXSEL];
  wire logic ext_trigger_enable = ctl_r[`TCSF_BIT_EXEN];
  wire logic run_control = ctl_r[`TCSF_BIT_RUN];
  wire logic capture_reload_select = ctl_r[`TCSF_BIT_CRSEL];

  // Register write strobe for this address.
  wire logic wr_hit = sfr_wr && (sfr_addr == `TCSF_CTL_ADDR);
  // Either baud select puts the timer in baud generator mode.
  wire logic baud_sel = rx_baud_source_select || tx_baud_source_select;
  // Mode decode; baud selects override the capture/reload select.
  wire tcsf_mode_e mode = !run_control ? TCSF_OFF :
                          baud_sel ? TCSF_BAUD :
                          capture_reload_select ? TCSF_CAPTURE : TCSF_RELOAD;
  // Falling edge seen on synchronised stages only, never on the first.
  // A trigger held low gives only one edge until it goes high again.
  wire logic pin_fall = pin_s3_r && !pin_s2_r;
  // Edge is only honoured when the external enable is set.
  wire logic ext_evt = pin_fall && ext_trigger_enable;
  // Counter reaches its top and would wrap on this tick.
  wire logic at_max = (count_value_r == `TCSF_CNT_MAX);
  // Overflow happens only on a tick while running.
  wire logic ovf_evt = run_control && count_tick && at_max;
  // Overflow sets the flag only outside baud generator mode.
  wire logic ovf_set = ovf_evt && !baud_sel;
  // In capture mode an edge captures; otherwise it reloads.
  wire logic ext_capture = ext_evt && (mode == TCSF_CAPTURE);
  wire logic ext_reload = ext_evt && (mode != TCSF_CAPTURE);
  // Serial selects only choose the shift clock source in the variable-rate modes.
  wire logic var_mode = is_var_mode(uart_mode);
  wire logic rx_src = (var_mode && rx_baud_source_select) ? ovf_evt : other_timer_ovf;
  wire logic tx_src = (var_mode && tx_baud_source_select) ? ovf_evt : other_timer_ovf;

  // Next control byte: software write first, then hardware sets.
  // Hardware set wins over a same-cycle software clear so no event is lost.
  always_comb begin
    ctl_nxt = wr_hit ? sfr_wdata : ctl_r;
    // Flags are never cleared here by hardware, only set.
    if (ovf_set) begin
      ctl_nxt[`TCSF_BIT_OVF] = 1'b1;
    end
    if (ext_evt) begin
      ctl_nxt[`TCSF_BIT_EXF] = 1'b1;
    end
  end

  // Next counter value; a trigger reload beats a same-cycle tick.
  always_comb begin
    cnt_nxt = count_value_r;
    if (ext_reload) begin
      cnt_nxt = reload_value;
    end else if (ovf_evt) begin
      // Capture mode wraps to zero; reload and baud modes reload.
      cnt_nxt = (mode == TCSF_CAPTURE) ? `TCSF_CNT_ZERO : reload_value;
    end else if (run_control && count_tick) begin
      cnt_nxt = 16'(count_value_r + 16'h0001);
    end
  end

  // Pin synchroniser; its first stage feeds only the second.
  // Stages reset high so a pin idling high gives no false edge after reset.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_s3_r <= 1'b1;
    end else begin
      pin_s1_r <= ext_trigger_pin;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  // Register, counter and capture strobe.
  // Flags and selects share one register so a read always sees a coherent byte.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl_r <= `TCSF_CTL_RESET;
      count_value_r <= `TCSF_CNT_ZERO;
      capture_pulse_r <= 1'b0;
    end else begin
      ctl_r <= ctl_nxt;
      count_value_r <= cnt_nxt;
      capture_pulse_r <= ext_capture;
    end
  end

  // Registered outputs; read data lags the address by one cycle.
  // The interrupt follows the flags one cycle after they are stored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sfr_rdata_r <= `TCSF_RD_IDLE;
      counter_timer_select_r <= 1'b0;
      timer_irq_r <= 1'b0;
      rx_shift_tick_r <= 1'b0;
      tx_shift_tick_r <= 1'b0;
    end else begin
      sfr_rdata_r <= (sfr_addr == `TCSF_CTL_ADDR) ? ctl_r : `TCSF_RD_IDLE;
      counter_timer_select_r <= ctl_r[`TCSF_BIT_CTSEL];
      timer_irq_r <= irq_enable && (overflow_flag || external_event_flag);
      rx_shift_tick_r <= rx_src;
      tx_shift_tick_r <= tx_src;
    end
  end

  // Checks on the logic above.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Flag still set and no software write of zero to it in this cycle.
  // A write of one to a set flag keeps it, so only a zero write may drop it.
  sequence s_ovf_kept;
    overflow_flag && !(wr_hit && !sfr_wdata[`TCSF_BIT_OVF]);
  endsequence
  sequence s_exf_kept;
    external_event_flag && !(wr_hit && !sfr_wdata[`TCSF_BIT_EXF]);
  endsequence
  // The capture strobe stands for exactly one cycle, so the capture
  // registers outside latch one value per trigger edge.
  sequence s_cap_pulse;
    capture_pulse_r ##1 !capture_pulse_r;
  endsequence

  chk_ovf_flag_hold: assert property (s_ovf_kept |=> overflow_flag)
    else $error("overflow flag dropped without a software clear");
  chk_no_ovf_baud: assert property (ovf_evt && baud_sel && !overflow_flag && !wr_hit
    |=> !overflow_flag)
    else $error("overflow flag set in baud generator mode");
  chk_ext_flag_set: assert property (pin_fall && ext_trigger_enable |=> external_event_flag)
    else $error("enabled trigger edge did not set external flag");
  chk_irq_from_ext: assert property ($rose(external_event_flag) && irq_enable |=> timer_irq_r)
    else $error("external flag did not raise interrupt");
  chk_ext_flag_hold: assert property (s_exf_kept |=> external_event_flag)
    else $error("external flag dropped without a software clear");
  chk_rx_source: assert property (var_mode && rx_baud_source_select && ovf_evt
    |=> rx_shift_tick_r)
    else $error("receive clock missed this timer overflow");
  chk_tx_source: assert property (var_mode && !tx_baud_source_select
    |=> tx_shift_tick_r == $past(other_timer_ovf))
    else $error("transmit clock not from other timer");
  chk_fixed_mode: assert property (!var_mode
    |=> rx_shift_tick_r == $past(other_timer_ovf) && tx_shift_tick_r == $past(other_timer_ovf))
    else $error("selects applied outside variable-rate modes");
  chk_edge_gated: assert property (!ext_trigger_enable && !wr_hit
    |=> !capture_pulse_r && !$rose(external_event_flag))
    else $error("disabled trigger edge took effect");
  chk_capture_pulse: assert property (ext_evt && (mode == TCSF_CAPTURE) |=> s_cap_pulse)
    else $error("capture strobe was not a single-cycle pulse");
  chk_ovf_set: assert property (ovf_evt && !baud_sel |=> overflow_flag)
    else $error("wrap did not set overflow flag");
  // Capture mode has no reload, so its wrap must land on zero.
  chk_capture_wrap: assert property (ovf_evt && (mode == TCSF_CAPTURE)
    |=> count_value_r == `TCSF_CNT_ZERO)
    else $error("capture mode wrap did not reach zero");
  chk_baud_reload: assert property (ovf_evt && baud_sel && !ext_evt
    |=> count_value_r == $past(reload_value))
    else $error("baud mode did not auto-reload");
  chk_idle_hold: assert property (!run_control && !ext_evt |=> $stable(count_value_r))
    else $error("counter moved while stopped");
  chk_irq_gate: assert property (!irq_enable |=> !timer_irq_r)
    else $error("interrupt raised while disabled");
endmodule : tcsf_top

// file: tb/tb_top.sv
/* Self-checking bench for the timer control/status block.
   Assumes the logic/ files are compiled first; the bench drives every port itself. */
`timescale 1ns/10ps
module tb_top;
  import tcsf_pkg::*;
  // One expected result: which output to look at and the value it should hold.
  typedef struct {int sel; logic [15:0] v;} tcsf_note_s;
  logic core_clk, rst, sfr_wr, count_tick, ext_trigger_pin, irq_enable, other_timer_ovf, sh_clr;
  tcsf_byte_t sfr_addr, sfr_wdata, sfr_rdata_r;
  tcsf_word_t reload_value, count_value_r, rv;
  logic [1:0] uart_mode, sh_seen;
  logic cap_seen;
  logic capture_pulse_r, counter_timer_select_r, timer_irq_r, rx_shift_tick_r, tx_shift_tick_r;
  tcsf_note_s exp_q[$];
  tcsf_note_s nt;
  int bad_count, num_checks, seed, n;
  tcsf_top u_tcsf_top (.core_clk(core_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata_r(sfr_rdata_r), .count_tick(count_tick), .reload_value(reload_value),
    .ext_trigger_pin(ext_trigger_pin), .irq_enable(irq_enable), .other_timer_ovf(other_timer_ovf),
    .uart_mode(uart_mode), .count_value_r(count_value_r), .capture_pulse_r(capture_pulse_r),
    .counter_timer_select_r(counter_timer_select_r), .timer_irq_r(timer_irq_r),
    .rx_shift_tick_r(rx_shift_tick_r), .tx_shift_tick_r(tx_shift_tick_r));
  // A 100 ns clock period.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Shift pulses last one cycle, so they are caught in a sticky pair that the bench clears.
  always @(posedge core_clk) sh_seen <= sh_clr ? 2'b00 : (sh_seen | {rx_shift_tick_r, tx_shift_tick_r});
  // The capture strobe is one cycle long as well, so it is caught the same way.
  always @(posedge core_clk) cap_seen <= sh_clr ? 1'b0 : (cap_seen | capture_pulse_r);
  // Compares at the falling edge, when every output of the last rising edge has settled.
  always @(negedge core_clk) begin
    while (exp_q.size() > 0) begin
      nt = exp_q.pop_front();
      case (nt.sel)
        0: check("rdata", {8'h00, sfr_rdata_r}, nt.v);
        1: check("count", count_value_r, nt.v);
        2: check("irq", {15'h0000, timer_irq_r}, nt.v);
        3: check("shift", {14'h0000, sh_seen}, nt.v);
        4: check("ctsel", {15'h0000, counter_timer_select_r}, nt.v);
        default: check("capture", {15'h0000, cap_seen}, nt.v);
      endcase
    end
  end
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc
  // Notes an expectation for the state after the next rising edge.
  task automatic note(input int sel, input logic [15:0] v);
    @(posedge core_clk);
    exp_q.push_back('{sel, v});
  endtask : note
  task automatic w(input tcsf_byte_t a, input tcsf_byte_t d);
    @(posedge core_clk) begin
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
    end
    @(posedge core_clk) sfr_wr <= 1'b0;
  endtask : w
  // Read data is registered, so the answer stands one edge after the address.
  task automatic rd(input tcsf_byte_t a, input tcsf_byte_t v);
    @(posedge core_clk) sfr_addr <= a;
    note(0, {8'h00, v});
  endtask : rd
  task automatic ticks(input int k);
    repeat (k) @(posedge core_clk) count_tick <= 1'b1;
    @(posedge core_clk) count_tick <= 1'b0;
  endtask : ticks
  // The pin passes two sync flops, so six cycles cover the whole trigger path.
  task automatic fall();
    @(posedge core_clk) ext_trigger_pin <= 1'b0;
    cyc(6);
    @(posedge core_clk) ext_trigger_pin <= 1'b1;
  endtask : fall
  task automatic clr();
    @(posedge core_clk) sh_clr <= 1'b1;
    @(posedge core_clk) sh_clr <= 1'b0;
  endtask : clr
  task automatic other();
    @(posedge core_clk) other_timer_ovf <= 1'b1;
    @(posedge core_clk) other_timer_ovf <= 1'b0;
    cyc(3);
  endtask : other
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Cuts a hang short; the whole run needs well under this bound.
  initial begin
    cyc(5000);
    bad_count++;
    close_out();
  end
  initial begin
    seed = 32'ha02b;
    {rst, sh_clr, ext_trigger_pin} = 3'b111;
    {sfr_wr, count_tick, irq_enable, other_timer_ovf} = 4'h0;
    {sfr_addr, sfr_wdata, uart_mode} = 18'h00000;
    // A random reload near the top keeps each overflow only a few ticks away.
    rv = {12'hfff, 4'($random(seed))};
    reload_value = rv;
    cyc(20);
    rst <= 1'b0;
    sh_clr <= 1'b0;
    irq_enable <= 1'b1;
    rd(8'hc9, 8'h00);
    w(8'h55, 8'hff);
    rd(8'hc9, 8'h00);
    rd(8'h55, 8'h00);
    w(8'hc9, 8'h08);
    fall();
    rd(8'hc9, 8'h48);
    note(2, 16'h0001);
    note(1, rv);
    cyc(5);
    rd(8'hc9, 8'h48);
    w(8'hc9, 8'h0c);
    note(2, 16'h0000);
    n = 32'h10000 - rv;
    ticks(n);
    rd(8'hc9, 8'h8c);
    note(1, rv);
    note(2, 16'h0001);
    w(8'hc9, 8'h88);
    ticks(3);
    note(1, rv);
    rd(8'hc9, 8'h88);
    w(8'hc9, 8'h00);
    fall();
    rd(8'hc9, 8'h00);
    note(1, rv);
    @(posedge core_clk) uart_mode <= 2'h1;
    w(8'hc9, 8'h35);
    clr();
    ticks(n);
    cyc(2);
    rd(8'hc9, 8'h35);
    note(2, 16'h0000);
    note(3, 16'h0003);
    note(1, rv);
    clr();
    other();
    note(3, 16'h0000);
    @(posedge core_clk) uart_mode <= 2'h0;
    clr();
    other();
    note(3, 16'h0003);
    @(posedge core_clk) uart_mode <= 2'h3;
    w(8'hc9, 8'h25);
    clr();
    other();
    note(3, 16'h0001);
    // Capture mode: an edge pulses the strobe and leaves the count alone; a wrap lands on zero.
    w(8'hc9, 8'h0f);
    note(4, 16'h0001);
    clr();
    fall();
    note(5, 16'h0001);
    note(1, rv);
    rd(8'hc9, 8'h4f);
    ticks(n);
    rd(8'hc9, 8'hcf);
    note(1, 16'h0000);
    note(2, 16'h0001);
    @(posedge core_clk) irq_enable <= 1'b0;
    note(2, 16'h0000);
    cyc(2);
    close_out();
  end
endmodule : tb_top
